// ==== logic/mic_params.svh ====
// constants for the interrupt controller: offsets, fields, vectors
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH
`define MIC_OPT_ADDR      8'hC8
`define MIC_OPT_RESET     8'h00
`define MIC_BIT_LVL_SEL   6
`define MIC_BIT_EDGE_POL  5
`define MIC_BIT_GLB_EN    4
`define MIC_STAT_ADDR     8'hC9
`define MIC_VEC_NMI       12'hFFC
`define MIC_VEC_SRC1      12'hFF6
`define MIC_VEC_SRC2      12'hFF4
`define MIC_VEC_SRC3      12'hFF2
`define MIC_VEC_SRC4      12'hFF0
`define MIC_LDI_EARLY_CYC 3
`endif

// ==== logic/mic_pkg.sv ====
// types shared by the interrupt controller
package mic_pkg;
    typedef enum logic [2:0] {
        MIC_NORMAL = 3'b001,
        MIC_IRQ    = 3'b010,
        MIC_NMI    = 3'b100
    } mic_mode_type;
endpackage

// ==== logic/mic_irq_ctrl.sv ====
// interrupt controller: sources, arbitration, entry and return sequencing
//
// Summary of operation
// - four maskable sources plus one non-maskable, each with its own vector
// - vectors: src0 FFC, src1 FF6, src2 FF4, src3 FF2, src4 FF0
// - accepted request loads the selected vector into the program counter
// - several events ORed for sources 3 and 4, per-event flags stay readable
// - non-maskable preempts maskable handlers but not itself; maskable sources never nest
// - fixed priority among maskable: source 1 highest, source 4 lowest
// - global enable gates acceptance of maskable sources only; non-maskable always accepted
// - global enable also gates wake-up from stop/wait, non-maskable too
// - non-maskable request held in a flip-flop cleared at its entry
// - source 1 level (active low) when select set, else falling edge
// - source 2 edge only; polarity bit picks rising or falling
// - sources 3 and 4 are level sensitive, no storage
// - edge latch sets on edge, clears at entry; extra edges not counted
// - lines evaluated at instruction end; next instruction is replaced
// - entry swaps carry/zero to interrupt or non-maskable flag pair
// - push program counter, then inhibit maskable lines
// - clear the first request latch, then load the vector
// - return restores previous flag set and pops program counter
// - option register write-only at C8, no bit ops, resets to 00
// - maskable request in first 3 cycles of clearing write skips flag swap
// - option bits 7 and 3..0 are unused
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mic_params.svh"

module mic_irq_ctrl
    import mic_pkg::*;
#(
    parameter int N_EV3 = 3,
    parameter int N_EV4 = 4
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    input  wire logic             nmi_pin_n,
    input  wire logic             src1_pin,
    input  wire logic             src2_pin,
    input  wire logic [N_EV3-1:0] src3_events,
    input  wire logic [N_EV4-1:0] src4_events,
    input  wire logic             instr_end,
    input  wire logic             ldi_cycle,
    input  wire logic             return_from_interrupt_op,
    input  wire logic             sleeping,
    input  wire logic [11:0]      pc_in,
    input  wire logic             carry_in,
    input  wire logic             zero_in,
    output logic                  irq_take,
    output logic      [11:0]      pc_load,
    output logic                  pc_load_en,
    output logic      [11:0]      stack_push_data,
    output logic                  stack_push,
    output logic                  stack_pop,
    output logic                  flag_set_sel_irq,
    output logic                  flag_set_sel_nmi,
    output logic                  wake_up,
    output logic      [N_EV3-1:0] src3_flags,
    output logic      [N_EV4-1:0] src4_flags
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [11:0] vec_of(input logic [2:0] s);
        case (s)
            3'd0:    vec_of = `MIC_VEC_NMI;
            3'd1:    vec_of = `MIC_VEC_SRC1;
            3'd2:    vec_of = `MIC_VEC_SRC2;
            3'd3:    vec_of = `MIC_VEC_SRC3;
            default: vec_of = `MIC_VEC_SRC4;
        endcase
    endfunction

    // ****************************************************************
    // pin synchronisers: three stages, change seen when 2 and 3 agree
    // ****************************************************************
    logic [2:0] s0_r, s1_r, s2_r;
    logic [2:0] s0_nxt, s1_nxt, s2_nxt;
    logic [2:0] clean_r, clean_nxt;

    always_comb begin
        s0_nxt    = {src2_pin, src1_pin, nmi_pin_n};
        s1_nxt    = s0_r;
        s2_nxt    = s1_r;
        clean_nxt = clean_r;
        for (int i = 0; i < 3; i++) begin
            if (s1_r[i] == s2_r[i]) begin
                clean_nxt[i] = s2_r[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s0_r    <= 3'h7;
            s1_r    <= 3'h7;
            s2_r    <= 3'h7;
            clean_r <= 3'h7;
        end else if (ce) begin
            s0_r    <= s0_nxt;
            s1_r    <= s1_nxt;
            s2_r    <= s2_nxt;
            clean_r <= clean_nxt;
        end
    end

    // ****************************************************************
    // option register
    // ****************************************************************
    logic [7:0] opt_r, opt_nxt;
    logic       rd_stat_r, rd_stat_nxt;
    logic       glb_en, lvl_sel, pol_sel;
    logic       opt_wr;

    assign glb_en  = opt_r[`MIC_BIT_GLB_EN];
    assign lvl_sel = opt_r[`MIC_BIT_LVL_SEL];
    assign pol_sel = opt_r[`MIC_BIT_EDGE_POL];
    assign opt_wr  = reg_wr && (reg_addr == `MIC_OPT_ADDR);

    always_comb begin
        opt_nxt     = opt_r;
        rd_stat_nxt = reg_rd && (reg_addr == `MIC_STAT_ADDR);
        // unused bits never stored, whole-byte write only
        if (opt_wr) begin
            opt_nxt = reg_wdata & 8'h70;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            opt_r     <= `MIC_OPT_RESET;
            rd_stat_r <= 1'b0;
        end else if (ce) begin
            opt_r     <= opt_nxt;
            rd_stat_r <= rd_stat_nxt;
        end
    end

    // ****************************************************************
    // request capture
    // ****************************************************************
    logic       nmi_lat_r, nmi_lat_nxt;
    logic       e1_lat_r, e1_lat_nxt;
    logic       e2_lat_r, e2_lat_nxt;
    logic [2:0] prev_r, prev_nxt;
    logic       nmi_fall, s1_fall, s2_edge;
    logic [4:0] req;
    logic       clr_nmi, clr_1, clr_2;

    assign nmi_fall = prev_r[0] && !clean_r[0];
    assign s1_fall  = prev_r[1] && !clean_r[1];
    assign s2_edge  = pol_sel ? (!prev_r[2] && clean_r[2])
                          : (prev_r[2] && !clean_r[2]);

    always_comb begin
        prev_nxt    = clean_r;
        nmi_lat_nxt = nmi_lat_r;
        e1_lat_nxt  = e1_lat_r;
        e2_lat_nxt  = e2_lat_r;
        // set wins over clear; a held latch ignores later edges
        if (clr_nmi) nmi_lat_nxt = 1'b0;
        if (nmi_fall) nmi_lat_nxt = 1'b1;
        if (clr_1) e1_lat_nxt = 1'b0;
        if (s1_fall && !lvl_sel) e1_lat_nxt = 1'b1;
        if (clr_2) e2_lat_nxt = 1'b0;
        if (s2_edge) e2_lat_nxt = 1'b1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_r    <= 3'h7;
            nmi_lat_r <= 1'b0;
            e1_lat_r  <= 1'b0;
            e2_lat_r  <= 1'b0;
        end else if (ce) begin
            prev_r    <= prev_nxt;
            nmi_lat_r <= nmi_lat_nxt;
            e1_lat_r  <= e1_lat_nxt;
            e2_lat_r  <= e2_lat_nxt;
        end
    end

    // level sources have no storage; requester must hold the line
    assign req[0] = nmi_lat_r;
    assign req[1] = lvl_sel ? !clean_r[1] : e1_lat_r;
    assign req[2] = e2_lat_r;
    assign req[3] = |src3_events;
    assign req[4] = |src4_events;
    assign src3_flags = src3_events;
    assign src4_flags = src4_events;

    // ****************************************************************
    // arbitration and entry / return sequencing
    // ****************************************************************
    mic_mode_type mode_r, mode_nxt, saved_r, saved_nxt;
    logic [2:0]   ldi_cnt_r, ldi_cnt_nxt;
    logic         noswap_r, noswap_nxt;
    logic [2:0]   sel;
    logic         take_nmi, take_msk, early_ldi;

    // nmi may nest; maskable only from normal mode
    assign take_nmi = req[0] && mode_r != MIC_NMI;
    assign take_msk = glb_en && mode_r == MIC_NORMAL
                      && |req[4:1];

    always_comb begin
        sel = 3'd4;
        for (int i = 4; i >= 1; i--) begin
            if (req[i]) sel = 3'(i);
        end
        if (take_nmi) sel = 3'd0;
    end

    assign irq_take  = instr_end && (take_nmi || take_msk);
    assign clr_nmi   = irq_take && sel == 3'd0;
    assign clr_1     = irq_take && sel == 3'd1;
    assign clr_2     = irq_take && sel == 3'd2;
    assign early_ldi = opt_wr && reg_wdata == 8'h00
                       && ldi_cnt_r < 3'(`MIC_LDI_EARLY_CYC);

    always_comb begin
        mode_nxt    = mode_r;
        saved_nxt   = saved_r;
        noswap_nxt  = noswap_r;
        ldi_cnt_nxt = ldi_cycle ? ldi_cnt_r + 3'd1 : 3'd0;
        if (irq_take) begin
            saved_nxt = mode_r;
            mode_nxt  = take_nmi ? MIC_NMI : MIC_IRQ;
            // quirk: entry during early cycles of clearing write
            noswap_nxt = !take_nmi && ldi_cycle
                         && ldi_cnt_r < 3'(`MIC_LDI_EARLY_CYC);
        end else if (return_from_interrupt_op && mode_r != MIC_NORMAL) begin
            mode_nxt   = saved_r;
            saved_nxt  = MIC_NORMAL;
            noswap_nxt = 1'b0;
        end
        if (early_ldi) ldi_cnt_nxt = 3'd0;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_r    <= MIC_NORMAL;
            saved_r   <= MIC_NORMAL;
            noswap_r  <= 1'b0;
            ldi_cnt_r <= 3'd0;
        end else if (ce) begin
            mode_r    <= mode_nxt;
            saved_r   <= saved_nxt;
            noswap_r  <= noswap_nxt;
            ldi_cnt_r <= ldi_cnt_nxt;
        end
    end

    // ****************************************************************
    // outputs to the core
    // ****************************************************************
    logic [11:0] pc_load_r, pc_load_nxt;
    logic [11:0] push_r, push_nxt;
    logic [7:0]  rdata_r, rdata_nxt;

    always_comb begin
        pc_load_nxt = irq_take ? vec_of(sel) : pc_load_r;
        push_nxt    = irq_take ? pc_in : push_r;
        rdata_nxt   = 8'h00;
        // write-only option register reads as zero; status reads mode
        if (rd_stat_nxt) begin
            rdata_nxt = {4'h0, noswap_nxt, mode_nxt};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_load_r  <= 12'h000;
            push_r     <= 12'h000;
            rdata_r    <= 8'h00;
            pc_load_en <= 1'b0;
            stack_push <= 1'b0;
            stack_pop  <= 1'b0;
        end else if (ce) begin
            pc_load_r  <= pc_load_nxt;
            push_r     <= push_nxt;
            rdata_r    <= rdata_nxt;
            pc_load_en <= irq_take;
            stack_push <= irq_take;
            stack_pop  <= return_from_interrupt_op
                          && mode_r != MIC_NORMAL;
        end
    end

    assign pc_load          = pc_load_r;
    assign stack_push_data  = push_r;
    assign reg_rdata        = rdata_r;
    assign flag_set_sel_irq = mode_r == MIC_IRQ && !noswap_r;
    assign flag_set_sel_nmi = mode_r == MIC_NMI;
    // wake needs global enable even for the non-maskable source
    assign wake_up = sleeping && glb_en && |req;

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_NMI_VEC: assert property (@(posedge clk) disable iff (!rstn)
        ce && clr_nmi |=> pc_load == `MIC_VEC_NMI && pc_load_en)
        else $error("nmi vector wrong");
    AST_NO_MSK_NEST: assert property (@(posedge clk) disable iff (!rstn)
        mode_r != MIC_NORMAL && irq_take |-> take_nmi)
        else $error("maskable nested");
    AST_PRIO: assert property (@(posedge clk) disable iff (!rstn)
        irq_take && !take_nmi && req[1] |-> sel == 3'd1)
        else $error("priority wrong");
    AST_EN_GATE: assert property (@(posedge clk) disable iff (!rstn)
        !glb_en && irq_take |-> sel == 3'd0)
        else $error("maskable taken while disabled");
    AST_WAKE: assert property (@(posedge clk) disable iff (!rstn)
        wake_up |-> glb_en)
        else $error("wake without enable");
    AST_ENTRY_SEQ: assert property (@(posedge clk) disable iff (!rstn)
        ce && irq_take |=> stack_push && stack_push_data == $past(pc_in))
        else $error("push missing");
    AST_OPT_RESET: assert property (@(posedge clk) disable iff (!rstn)
        opt_r[7] == 1'b0 && opt_r[3:0] == 4'h0)
        else $error("unused option bits set");
    AST_NMI_CLR: assert property (@(posedge clk) disable iff (!rstn)
        ce && clr_nmi && !nmi_fall |=> !nmi_lat_r)
        else $error("nmi latch not cleared at entry");
    // only one saved level, so a return must land exactly on it
    AST_RET_POP: assert property (@(posedge clk) disable iff (!rstn)
        ce && return_from_interrupt_op && mode_r != MIC_NORMAL && !irq_take
        |=> mode_r == $past(saved_r) && stack_pop)
        else $error("return did not restore mode");
    AST_NOSWAP: assert property (@(posedge clk) disable iff (!rstn)
        ce && irq_take && !take_nmi && ldi_cycle
        && ldi_cnt_r < 3'(`MIC_LDI_EARLY_CYC) |=> !flag_set_sel_irq)
        else $error("flag pair swapped during clearing write");
    AST_TAKE_END: assert property (@(posedge clk) disable iff (!rstn)
        irq_take |-> instr_end)
        else $error("taken mid instruction");

endmodule // mic_irq_ctrl
`default_nettype wire

// ==== tb/mic_core_model.sv ====
// core sequencer stand-in: instruction ends and program counter
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        sleeping,
    input  wire logic        pc_load_en,
    input  wire logic [11:0] pc_load,
    output logic             instr_end,
    output logic      [11:0] pc_in
);
    // ****************************************
    // four-cycle instructions
    // ****************************************
    logic [1:0] phase_r;
    // a sleeping core finishes no instruction
    assign instr_end = (phase_r == 2'h3) && !sleeping;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= 2'h0;
            pc_in   <= 12'h100;
        end else begin
            phase_r <= phase_r + 2'h1;
            if (pc_load_en) begin
                pc_in <= pc_load;
            end else if (instr_end) begin
                pc_in <= pc_in + 12'h001;
            end
        end
    end
endmodule // mic_core_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "mic_params.svh"
module testbench;
    import mic_pkg::*;
    typedef struct packed {
        logic [4:0]  req;
        logic [11:0] vec;
    } mic_row_type;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        nmi_pin_n = 1'b1;
    logic        src1_pin = 1'b1;
    logic        src2_pin = 1'b1;
    logic [2:0]  src3_events = 3'h0;
    logic [3:0]  src4_events = 4'h0;
    logic        ret_op = 1'b0;
    logic        ldi_cycle = 1'b0;
    logic        sleeping = 1'b0;
    logic [7:0]  reg_rdata;
    logic [7:0]  rd_v;
    logic        instr_end, irq_take, pc_load_en, stack_push, stack_pop;
    logic        sel_irq, sel_nmi, wake_up;
    logic [11:0] pc_in, pc_load, stack_push_data, pc_at_take;
    logic [11:0] last_vec = 12'h000;
    logic [11:0] take_cnt = 12'h000;
    logic [2:0]  src3_flags;
    logic [3:0]  src4_flags;
    int          mismatches = 0;
    int          n_checks = 0;
    int          cycles = 0;
    mic_row_type rows [8] = '{'{5'h01, `MIC_VEC_NMI}, '{5'h02, `MIC_VEC_SRC1},
        '{5'h04, `MIC_VEC_SRC2}, '{5'h08, `MIC_VEC_SRC3},
        '{5'h10, `MIC_VEC_SRC4}, '{5'h18, `MIC_VEC_SRC3},
        '{5'h12, `MIC_VEC_SRC1}, '{5'h0C, `MIC_VEC_SRC2}};

    mic_irq_ctrl #(.N_EV3(3), .N_EV4(4)) dut_u (
        .clk(clk), .rstn(rstn), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .nmi_pin_n(nmi_pin_n), .src1_pin(src1_pin),
        .src2_pin(src2_pin), .src3_events(src3_events),
        .src4_events(src4_events), .instr_end(instr_end),
        .ldi_cycle(ldi_cycle), .return_from_interrupt_op(ret_op),
        .sleeping(sleeping), .pc_in(pc_in),
        .carry_in(1'b0), .zero_in(1'b0), .irq_take(irq_take),
        .pc_load(pc_load), .pc_load_en(pc_load_en),
        .stack_push_data(stack_push_data), .stack_push(stack_push),
        .stack_pop(stack_pop), .flag_set_sel_irq(sel_irq),
        .flag_set_sel_nmi(sel_nmi), .wake_up(wake_up),
        .src3_flags(src3_flags), .src4_flags(src4_flags));
    mic_core_model core_u (.clk(clk), .rstn(rstn), .sleeping(sleeping),
        .pc_load_en(pc_load_en), .pc_load(pc_load), .instr_end(instr_end),
        .pc_in(pc_in));

    always #4 clk = ~clk;

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // entry watcher; cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (irq_take === 1'b1) pc_at_take <= pc_in;
        if (pc_load_en === 1'b1) begin
            take_cnt <= take_cnt + 12'h001;
            last_vec <= pc_load;
            chk(stack_push_data, pc_at_take);
            chk({11'h0, stack_push}, 12'h001);
        end
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    // ****************************************
    // bus, request and wait tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic apply(input logic [4:0] r);
        @(posedge clk);
        nmi_pin_n <= !r[0];
        src1_pin <= !r[1];
        src2_pin <= !r[2];
        src3_events <= {2'b00, r[3]};
        src4_events <= {3'b000, r[4]};
    endtask
    task automatic expect_take(input logic [11:0] exp);
        logic [11:0] c0;
        int n;
        c0 = take_cnt;
        n = 0;
        while (take_cnt == c0 && n < 60) begin
            @(posedge clk);
            n++;
        end
        #1 chk(take_cnt - c0, 12'h001);
        chk(last_vec, exp);
    endtask
    task automatic expect_none();
        logic [11:0] c0;
        c0 = take_cnt;
        repeat (40) @(posedge clk);
        chk(take_cnt - c0, 12'h000);
    endtask
    task automatic ret_irq();
        @(posedge clk);
        ret_op <= 1'b1;
        @(posedge clk);
        ret_op <= 1'b0;
        #1 chk({11'h0, stack_pop}, 12'h001);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(`MIC_OPT_ADDR, rd_v);
        chk({4'h0, rd_v}, 12'h000);
        rd(`MIC_STAT_ADDR, rd_v);
        chk({4'h0, rd_v}, 12'h001);
        rd(8'h10, rd_v);
        chk({4'h0, rd_v}, 12'h000);
        // enable off: maskable blocked, non-maskable still taken
        apply(5'h08);
        expect_none();
        apply(5'h09);
        expect_take(`MIC_VEC_NMI);
        apply(5'h00);
        ret_irq();
        @(posedge clk);
        sleeping <= 1'b1;
        apply(5'h01);
        repeat (10) @(posedge clk);
        chk({11'h0, wake_up}, 12'h000);
        wr(`MIC_OPT_ADDR, 8'h10);
        #1 chk({11'h0, wake_up}, 12'h001);
        @(posedge clk);
        sleeping <= 1'b0;
        expect_take(`MIC_VEC_NMI);
        apply(5'h00);
        ret_irq();
        $display("test enable and wake done");
        // sleeping core holds off instruction end: edge and level
        // sources of a row are all pending at one sample
        foreach (rows[i]) begin
            apply(rows[i].req);
            sleeping <= 1'b1;
            repeat (7) @(posedge clk);
            #1 chk({11'h0, wake_up}, 12'h001);
            chk({9'h0, src3_flags}, {11'h0, rows[i].req[3]});
            chk({8'h0, src4_flags}, {11'h0, rows[i].req[4]});
            @(posedge clk);
            sleeping <= 1'b0;
            expect_take(rows[i].vec);
            chk({10'h0, sel_nmi, sel_irq},
                rows[i].req[0] ? 12'h2 : 12'h1);
            apply(5'h00);
            ret_irq();
        end
        $display("test vector table done");
        // non-maskable nests, maskable never does
        apply(5'h08);
        expect_take(`MIC_VEC_SRC3);
        apply(5'h09);
        expect_take(`MIC_VEC_NMI);
        apply(5'h18);
        expect_none();
        ret_irq();
        chk({10'h0, sel_nmi, sel_irq}, 12'h001);
        expect_none();
        apply(5'h00);
        ret_irq();
        chk({10'h0, sel_nmi, sel_irq}, 12'h000);
        $display("test nesting done");
        // level source 1 retakes while still held low
        wr(`MIC_OPT_ADDR, 8'h50);
        apply(5'h02);
        expect_take(`MIC_VEC_SRC1);
        ret_irq();
        expect_take(`MIC_VEC_SRC1);
        apply(5'h00);
        // released pin needs the synchroniser to drain before return
        repeat (6) @(posedge clk);
        ret_irq();
        expect_none();
        $display("test level source done");
        // rising polarity; a falling edge must not count
        wr(`MIC_OPT_ADDR, 8'h30);
        src2_pin <= 1'b0;
        expect_none();
        src2_pin <= 1'b1;
        expect_take(`MIC_VEC_SRC2);
        ret_irq();
        apply(5'h08);
        expect_take(`MIC_VEC_SRC3);
        @(posedge clk);
        repeat (2) begin
            src2_pin <= 1'b0;
            repeat (8) @(posedge clk);
            src2_pin <= 1'b1;
            repeat (8) @(posedge clk);
        end
        apply(5'h00);
        ret_irq();
        expect_take(`MIC_VEC_SRC2);
        ret_irq();
        expect_none();
        $display("test edge storage done");
        // entry in the first cycle of a clearing write keeps normal flags
        @(posedge clk iff instr_end);
        repeat (3) @(posedge clk);
        ldi_cycle <= 1'b1;
        src3_events <= 3'h1;
        @(posedge clk);
        ldi_cycle <= 1'b0;
        expect_take(`MIC_VEC_SRC3);
        chk({10'h0, sel_nmi, sel_irq}, 12'h000);
        rd(`MIC_STAT_ADDR, rd_v);
        chk({4'h0, rd_v}, 12'h00A);
        apply(5'h00);
        $display("test early clearing write done");
        // mid-run reset: mode, no-swap flag and option register clear
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(`MIC_STAT_ADDR, rd_v);
        chk({4'h0, rd_v}, 12'h001);
        apply(5'h08);
        expect_none();
        apply(5'h00);
        $display("test reset done");
        end_sim();
    end
endmodule // testbench
`default_nettype wire
